// File: logic/flash_fetch_pkg.sv
// constants, commands and states shared by the code-fetch controller
// assumes a 50 MHz core clock and a separate serial link clock
package flash_fetch_pkg;

   // serial flash opcodes and fill pattern
   localparam logic [7:0]  OPC_FAST_READ = 8'h0B;
   localparam logic [7:0]  OPC_DUAL_READ = 8'h3B;
   localparam logic [7:0]  DUMMY_FILL    = 8'h00;

   // boot signature: ascii bytes, first byte at the probe address
   localparam logic [23:0] SIG_ADDR      = 24'h00FFFA;
   localparam logic [23:0] BOOT_ADDR     = 24'h000000;
   localparam logic [31:0] SIG_WORD      = 32'h32444655;
   localparam logic [1:0]  SIG_LAST      = 2'h3;
   localparam logic [23:0] ADDR_STEP     = 24'h000001;

   // serial sequence lengths in serial clocks
   localparam logic [5:0]  HDR_CLKS      = 6'h28;
   localparam logic [5:0]  SINGLE_CLKS   = 6'h08;
   localparam logic [5:0]  DUAL_CLKS     = 6'h04;

   // core cycles allowed for the strap synchroniser to fill
   localparam logic [1:0]  STRAP_SETTLE  = 2'h3;

   // count of synchronised bits on each side
   localparam int          CORE_SYNC_N   = 2;
   localparam int          LINK_SYNC_N   = 4;

   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_OPEN  = 2'b01,
      OP_NEXT  = 2'b10,
      OP_CLOSE = 2'b11
   } link_op_e;

   typedef struct packed {
      link_op_e    op;
      logic        dual;
      logic [23:0] addr;
   } link_cmd_s;

   typedef enum logic [2:0] {
      C_LATCH  = 3'b000,
      C_PROBE  = 3'b001,
      C_PWAIT  = 3'b010,
      C_PCLOSE = 3'b011,
      C_READY  = 3'b100,
      C_FCLOSE = 3'b101,
      C_FWAIT  = 3'b110
   } core_state_e;

   typedef enum logic [2:0] {
      L_IDLE   = 3'b000,
      L_SHIFT  = 3'b001,
      L_READ   = 3'b010,
      L_DRAIN  = 3'b011,
      L_HOLD   = 3'b100
   } link_state_e;

endpackage

// File: logic/bit_sync.sv
// two-flop level synchroniser
// assumes rst_b_i is asynchronous, active low
`timescale 1ns/10ps
module bit_sync (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic meta;

   // meta is read by q_o alone
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule

// File: logic/spi_flash_code_fetch.sv
// serial flash code-fetch controller: boot probe, fast and dual reads
// assumes link_clk_i at twice the top serial rate; flash in mode 0
// Operation
// - after reset read up to four bytes from 0xFFFA, stopping at the first byte that differs from the signature
// - valid signature enables external code; processor released to 0x0000
// - no valid signature keeps processor on internal read-only memory
// - single-bit read drops select, sends opcode 0x0B and 24-bit address
// - one dummy byte follows the address before data is captured
// - single-bit mode captures each data byte over eight serial clocks
// - full byte captured raises ready and hands one byte to processor
// - fetch at previous address plus one keeps select low, reads one more
// - any other fetch address ends the transaction with select high
// - dual data reads only allowed at the lower serial rate
// - dual read sends opcode 0x3B, 24-bit address, then dummy byte
// - dual data moves two bits per clock, one byte in four clocks
// - strap low selects 30 MHz rate, strap high selects 60 MHz
// - strap caught after reset release and held until next reset
`timescale 1ns/10ps
module spi_flash_code_fetch (
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        link_clk_i,
   input  wire logic        fetch_req_i,
   input  wire logic [23:0] fetch_addr_i,
   input  wire logic        dual_mode_en_i,
   input  wire logic        flash_io0_i,
   input  wire logic        flash_serial_in_i,
   output logic             fetch_rdy_o,
   output logic [7:0]       fetch_data_o,
   output logic             ext_code_en_o,
   output logic             cpu_hold_o,
   output logic             rate_fast_o,
   output logic             flash_sel_b_o,
   output logic             flash_sclk_o,
   output logic             flash_io0_o,
   output logic             flash_io0_oe_o
);

   // ---------------- core domain ----------------
   flash_fetch_pkg::core_state_e   cstate;
   flash_fetch_pkg::link_cmd_s     cmd;
   logic [1:0]                     settle;
   logic                           req_tg;
   logic                           ack_seen;
   logic [1:0]                     sig_idx;
   logic                           sig_ok;
   logic                           open_tr;
   logic [23:0]                    last_addr;
   logic [23:0]                    take_addr;
   logic [flash_fetch_pkg::CORE_SYNC_N-1:0] core_async;
   logic [flash_fetch_pkg::CORE_SYNC_N-1:0] core_sync;

   // ---------------- link domain ----------------
   flash_fetch_pkg::link_state_e   lstate;
   logic                           link_rst_b;
   logic                           req_seen;
   logic                           ack_tg;
   logic                           div;
   logic                           dual;
   logic [5:0]                     cnt;
   logic [39:0]                    shreg;
   logic [1:0]                     pipe;
   logic [7:0]                     rx;
   logic [7:0]                     rx_hold;
   logic [flash_fetch_pkg::LINK_SYNC_N-1:0] link_async;
   logic [flash_fetch_pkg::LINK_SYNC_N-1:0] link_sync;

   function automatic flash_fetch_pkg::link_cmd_s mk_cmd(
      input flash_fetch_pkg::link_op_e op,
      input logic                      dl,
      input logic [23:0]               addr
   );
      flash_fetch_pkg::link_cmd_s c;
      c.op   = op;
      c.dual = dl;
      c.addr = addr;
      return c;
   endfunction

   function automatic logic [7:0] sig_byte_at(input logic [1:0] idx);
      logic [7:0] b;
      b = 8'h00;
      unique case (idx)
         2'h0: b = flash_fetch_pkg::SIG_WORD[31:24];
         2'h1: b = flash_fetch_pkg::SIG_WORD[23:16];
         2'h2: b = flash_fetch_pkg::SIG_WORD[15:8];
         2'h3: b = flash_fetch_pkg::SIG_WORD[7:0];
      endcase
      return b;
   endfunction

   // crossings: bit 1 ack toggle, bit 0 strap pin
   assign core_async = {ack_tg, flash_io0_i};
   // crossings: req toggle, rate level, io0 and io1 data pins
   assign link_async = {req_tg, rate_fast_o, flash_io0_i,
                        flash_serial_in_i};

   genvar gi;
   generate
      for (gi = 0; gi < flash_fetch_pkg::CORE_SYNC_N; gi++) begin : g_cs
         bit_sync u_sync (
            .clk_i   (core_clk_i),
            .rst_b_i (rst_b_i),
            .d_i     (core_async[gi]),
            .q_o     (core_sync[gi])
         );
      end
      for (gi = 0; gi < flash_fetch_pkg::LINK_SYNC_N; gi++) begin : g_ls
         bit_sync u_sync (
            .clk_i   (link_clk_i),
            .rst_b_i (link_rst_b),
            .d_i     (link_async[gi]),
            .q_o     (link_sync[gi])
         );
      end
   endgenerate

   // link reset: asserted at once, released on a link edge
   bit_sync u_link_rst (
      .clk_i   (link_clk_i),
      .rst_b_i (rst_b_i),
      .d_i     (1'b1),
      .q_o     (link_rst_b)
   );

   // core side decode
   wire       ack_new   = core_sync[1] ^ ack_seen;
   wire [23:0] next_seq = last_addr + flash_fetch_pkg::ADDR_STEP;
   wire       seq_hit   = open_tr & (fetch_addr_i == next_seq);
   wire       dual_ok   = dual_mode_en_i & ~rate_fast_o;
   wire [7:0] sig_want  = sig_byte_at(sig_idx);
   wire       sig_match = (rx_hold == sig_want);
   wire       fetch_go  = fetch_req_i & ext_code_en_o;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_seen <= 1'b0;
      end else begin
         ack_seen <= core_sync[1];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cstate        <= flash_fetch_pkg::C_LATCH;
         cmd           <= '{flash_fetch_pkg::OP_NONE, 1'b0,
                            flash_fetch_pkg::BOOT_ADDR};
         settle        <= 2'h0;
         req_tg        <= 1'b0;
         sig_idx       <= 2'h0;
         sig_ok        <= 1'b0;
         open_tr       <= 1'b0;
         last_addr     <= flash_fetch_pkg::BOOT_ADDR;
         take_addr     <= flash_fetch_pkg::BOOT_ADDR;
         rate_fast_o   <= 1'b0;
         ext_code_en_o <= 1'b0;
         cpu_hold_o    <= 1'b1;
         fetch_rdy_o   <= 1'b0;
         fetch_data_o  <= 8'h00;
      end else begin
         fetch_rdy_o <= 1'b0;
         unique case (cstate)
            flash_fetch_pkg::C_LATCH: begin
               // io0 is undriven here, so the pin shows the strap
               if (settle == flash_fetch_pkg::STRAP_SETTLE) begin
                  rate_fast_o <= core_sync[0];
                  cstate      <= flash_fetch_pkg::C_PROBE;
               end else begin
                  settle <= settle + 2'h1;
               end
            end
            flash_fetch_pkg::C_PROBE: begin
               // probe always single-bit: works with any flash
               cmd     <= mk_cmd(flash_fetch_pkg::OP_OPEN, 1'b0,
                                 flash_fetch_pkg::SIG_ADDR);
               req_tg  <= ~req_tg;
               sig_idx <= 2'h0;
               sig_ok  <= 1'b1;
               cstate  <= flash_fetch_pkg::C_PWAIT;
            end
            flash_fetch_pkg::C_PWAIT: begin
               if (ack_new) begin
                  if (!sig_match ||
                      sig_idx == flash_fetch_pkg::SIG_LAST) begin
                     sig_ok <= sig_ok & sig_match;
                     cmd    <= mk_cmd(flash_fetch_pkg::OP_CLOSE, 1'b0,
                                      flash_fetch_pkg::SIG_ADDR);
                     req_tg <= ~req_tg;
                     cstate <= flash_fetch_pkg::C_PCLOSE;
                  end else begin
                     sig_idx <= sig_idx + 2'h1;
                     cmd     <= mk_cmd(flash_fetch_pkg::OP_NEXT, 1'b0,
                                       flash_fetch_pkg::SIG_ADDR);
                     req_tg  <= ~req_tg;
                  end
               end
            end
            flash_fetch_pkg::C_PCLOSE: begin
               if (ack_new) begin
                  ext_code_en_o <= sig_ok;
                  cpu_hold_o    <= 1'b0;
                  cstate        <= flash_fetch_pkg::C_READY;
               end
            end
            flash_fetch_pkg::C_READY: begin
               // internal-rom fetches are not ours to answer
               if (fetch_go) begin
                  take_addr <= fetch_addr_i;
                  req_tg    <= ~req_tg;
                  if (seq_hit) begin
                     cmd    <= mk_cmd(flash_fetch_pkg::OP_NEXT, cmd.dual,
                                      fetch_addr_i);
                     cstate <= flash_fetch_pkg::C_FWAIT;
                  end else if (open_tr) begin
                     cmd    <= mk_cmd(flash_fetch_pkg::OP_CLOSE, cmd.dual,
                                      fetch_addr_i);
                     cstate <= flash_fetch_pkg::C_FCLOSE;
                  end else begin
                     cmd    <= mk_cmd(flash_fetch_pkg::OP_OPEN, dual_ok,
                                      fetch_addr_i);
                     cstate <= flash_fetch_pkg::C_FWAIT;
                  end
               end
            end
            flash_fetch_pkg::C_FCLOSE: begin
               if (ack_new) begin
                  open_tr <= 1'b0;
                  cmd     <= mk_cmd(flash_fetch_pkg::OP_OPEN, dual_ok,
                                    take_addr);
                  req_tg  <= ~req_tg;
                  cstate  <= flash_fetch_pkg::C_FWAIT;
               end
            end
            flash_fetch_pkg::C_FWAIT: begin
               if (ack_new) begin
                  fetch_data_o <= rx_hold;
                  fetch_rdy_o  <= 1'b1;
                  last_addr    <= take_addr;
                  open_tr      <= 1'b1;
                  cstate       <= flash_fetch_pkg::C_READY;
               end
            end
            default: begin
               cstate <= flash_fetch_pkg::C_READY;
            end
         endcase
      end
   end

   // ---------------- link side decode ----------------
   wire       req_new  = link_sync[3] ^ req_seen;
   wire       rate_hi  = link_sync[2];
   wire       tick     = rate_hi | div;
   wire       rise     = tick & ~flash_sclk_o;
   wire       fall     = tick & flash_sclk_o;
   wire       rd_rise  = rise & (lstate == flash_fetch_pkg::L_READ);
   wire       take_ok  = (lstate == flash_fetch_pkg::L_IDLE) |
                         (lstate == flash_fetch_pkg::L_HOLD);
   wire [7:0] opcode   = cmd.dual ? flash_fetch_pkg::OPC_DUAL_READ
                                  : flash_fetch_pkg::OPC_FAST_READ;
   wire [5:0] byte_clk = dual ? flash_fetch_pkg::DUAL_CLKS
                              : flash_fetch_pkg::SINGLE_CLKS;
   wire [7:0] rx_shift = dual ? {rx[5:0], link_sync[0], link_sync[1]}
                              : {rx[6:0], link_sync[0]};

   // slow rate gets one serial edge every second link cycle
   always_ff @(posedge link_clk_i or negedge link_rst_b) begin
      if (!link_rst_b) begin
         div      <= 1'b0;
         pipe     <= 2'b00;
         req_seen <= 1'b0;
      end else begin
         div      <= ~rate_hi & ~div;
         // sync delay is matched by delaying the sample strobe
         pipe     <= {pipe[0], rd_rise};
         if (take_ok) begin
            req_seen <= link_sync[3];
         end
      end
   end

   always_ff @(posedge link_clk_i or negedge link_rst_b) begin
      if (!link_rst_b) begin
         rx <= 8'h00;
      end else if (pipe[1]) begin
         rx <= rx_shift;
      end
   end

   always_ff @(posedge link_clk_i or negedge link_rst_b) begin
      if (!link_rst_b) begin
         lstate         <= flash_fetch_pkg::L_IDLE;
         flash_sel_b_o  <= 1'b1;
         flash_sclk_o   <= 1'b0;
         flash_io0_o    <= 1'b0;
         flash_io0_oe_o <= 1'b0;
         shreg          <= 40'h0000000000;
         cnt            <= 6'h00;
         dual           <= 1'b0;
         ack_tg         <= 1'b0;
         rx_hold        <= 8'h00;
      end else begin
         unique case (lstate)
            flash_fetch_pkg::L_IDLE: begin
               if (req_new) begin
                  if (cmd.op == flash_fetch_pkg::OP_OPEN) begin
                     flash_sel_b_o  <= 1'b0;
                     shreg          <= {opcode, cmd.addr,
                                        flash_fetch_pkg::DUMMY_FILL};
                     flash_io0_o    <= opcode[7];
                     flash_io0_oe_o <= 1'b1;
                     cnt            <= flash_fetch_pkg::HDR_CLKS;
                     dual           <= cmd.dual;
                     lstate         <= flash_fetch_pkg::L_SHIFT;
                  end else begin
                     ack_tg <= ~ack_tg;
                  end
               end
            end
            flash_fetch_pkg::L_SHIFT: begin
               // opcode, address and dummy byte go out on io0 only
               if (rise) begin
                  flash_sclk_o <= 1'b1;
                  cnt          <= cnt - 6'h01;
               end else if (fall) begin
                  flash_sclk_o <= 1'b0;
                  if (cnt == 6'h00) begin
                     flash_io0_oe_o <= ~dual;
                     cnt            <= byte_clk;
                     lstate         <= flash_fetch_pkg::L_READ;
                  end else begin
                     shreg       <= {shreg[38:0], 1'b0};
                     flash_io0_o <= shreg[38];
                  end
               end
            end
            flash_fetch_pkg::L_READ: begin
               if (rise) begin
                  flash_sclk_o <= 1'b1;
                  cnt          <= cnt - 6'h01;
               end else if (fall) begin
                  flash_sclk_o <= 1'b0;
                  if (cnt == 6'h00) begin
                     lstate <= flash_fetch_pkg::L_DRAIN;
                  end
               end
            end
            flash_fetch_pkg::L_DRAIN: begin
               // wait for the last delayed sample before handing over
               if (pipe == 2'b00) begin
                  rx_hold <= rx;
                  ack_tg  <= ~ack_tg;
                  lstate  <= flash_fetch_pkg::L_HOLD;
               end
            end
            flash_fetch_pkg::L_HOLD: begin
               // select stays low, clock idles low between bytes
               if (req_new) begin
                  if (cmd.op == flash_fetch_pkg::OP_NEXT) begin
                     cnt    <= byte_clk;
                     lstate <= flash_fetch_pkg::L_READ;
                  end else begin
                     flash_sel_b_o  <= 1'b1;
                     flash_io0_oe_o <= 1'b0;
                     ack_tg         <= ~ack_tg;
                     lstate         <= flash_fetch_pkg::L_IDLE;
                  end
               end
            end
            default: begin
               lstate <= flash_fetch_pkg::L_IDLE;
            end
         endcase
      end
   end

endmodule

// File: sim/flash_fetch_properties.sv
// port checker for the code-fetch controller
// assumes binding onto spi_flash_code_fetch
`timescale 1ns/10ps
module flash_fetch_properties (
   input  wire logic       core_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       link_clk_i,
   input  wire logic       fetch_rdy_o,
   input  wire logic [7:0] fetch_data_o,
   input  wire logic       ext_code_en_o,
   input  wire logic       cpu_hold_o,
   input  wire logic       rate_fast_o,
   input  wire logic       flash_sel_b_o,
   input  wire logic       flash_sclk_o
);
   rdy_spacing_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      fetch_rdy_o |=> !fetch_rdy_o [*4]) else $error("ready too close");
   data_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !fetch_rdy_o |-> $stable(fetch_data_o)) else $error("data moved");
   code_sel_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !cpu_hold_o && !$past(cpu_hold_o) && !$past(cpu_hold_o, 2)
      |-> $stable(ext_code_en_o)) else $error("code select moved");
   rate_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !cpu_hold_o |-> $stable(rate_fast_o)) else $error("rate moved");
   int_rom_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !ext_code_en_o |-> !fetch_rdy_o) else $error("fetch on rom");
   probe_quiet_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      cpu_hold_o |-> !fetch_rdy_o) else $error("fetch during probe");
   sclk_idle_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_b_i)
      flash_sel_b_o |-> !flash_sclk_o) else $error("clock while idle");
   fast_sclk_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_b_i)
      rate_fast_o && $rose(flash_sclk_o) |=> $fell(flash_sclk_o))
      else $error("fast clock shape");
   slow_sclk_a: assert property (
      @(posedge link_clk_i) disable iff (!rst_b_i)
      !rate_fast_o && $rose(flash_sclk_o) |=> flash_sclk_o ##1 !flash_sclk_o)
      else $error("slow clock shape");
   cover property (@(posedge core_clk_i) ext_code_en_o && fetch_rdy_o);
   cover property (@(posedge core_clk_i) $fell(cpu_hold_o) && !ext_code_en_o);
   cover property (@(posedge link_clk_i) rate_fast_o && $rose(flash_sclk_o));
endmodule

bind spi_flash_code_fetch flash_fetch_properties u_props (
   .core_clk_i, .rst_b_i, .link_clk_i, .fetch_rdy_o, .fetch_data_o,
   .ext_code_en_o, .cpu_hold_o, .rate_fast_o, .flash_sel_b_o, .flash_sclk_o
);

// File: sim/flash_model.sv
// serial flash partner: fast and dual fast reads, mode 0
// assumes opcode and address arrive msb first on io0
`timescale 1ns/10ps
module flash_model (
   input  wire logic sel_b_i,
   input  wire logic sclk_i,
   input  wire logic io0_i,
   input  wire logic sig_ok_i,
   output logic      io0_o,
   output logic      io0_oe_o,
   output logic      io1_o
);
   logic [31:0] hdr = 32'h0;
   logic [7:0]  b;
   int          cnt = 0;
   int          opens = 0;
   int          k;
   wire         dual = (hdr[31:24] == 8'h3B);

   function automatic logic [7:0] mem_byte(input logic [23:0] a);
      logic [7:0] s;
      case (a[2:0])
         3'h2: s = 8'h32;
         3'h3: s = 8'h44;
         3'h4: s = 8'h46;
         default: s = 8'h55;
      endcase
      if (sig_ok_i && a >= 24'h00FFFA && a <= 24'h00FFFD)
         return s;
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction

   initial begin
      io0_o = 1'b0;
      io0_oe_o = 1'b0;
      io1_o = 1'b0;
   end
   // one process owns cnt; select only falls while the clock idles low
   always @(posedge sclk_i or negedge sel_b_i) begin
      if (!sclk_i) begin
         cnt = 0;
         opens++;
      end else if (!sel_b_i) begin
         if (cnt < 32)
            hdr = {hdr[30:0], io0_i};
         cnt++;
      end
   end
   // undriven phases toggle so a stale bit never passes for data
   always @(negedge sclk_i or posedge sel_b_i) begin
      k = cnt - 40;
      if (sel_b_i || cnt < 40) begin
         io1_o <= ~io1_o;
         io0_oe_o <= 1'b0;
      end else if (dual) begin
         b = mem_byte(hdr[23:0] + 24'(k / 4));
         io1_o <= b[7 - 2 * (k % 4)];
         io0_o <= b[6 - 2 * (k % 4)];
         io0_oe_o <= 1'b1;
      end else begin
         b = mem_byte(hdr[23:0] + 24'(k / 8));
         io1_o <= b[7 - k % 8];
      end
   end
endmodule

// File: sim/tb_top.sv
// self-checking bench: boot probe, single and dual streamed fetches
// assumes flash_model as the flash; rate strap seen on the io0 pin
`timescale 1ns/10ps
module tb_top;
   logic        core_clk, link_clk, rst_b, req, dual_en, strap, sig_ok;
   logic        rdy, ext, hold, fast, sel_b, sclk, d_io0, d_oe;
   logic        f_io0, f_oe, f_io1, open_s, mode, st_l;
   logic [23:0] addr, last_a;
   logic [7:0]  data;
   logic [31:0] rs, r;
   int          fails, compares, opens0, nb;
   int          cyc = 0;
   wire         io0_w = d_oe ? d_io0 : (f_oe && !sel_b) ? f_io0 : strap;

   spi_flash_code_fetch u_dut (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .link_clk_i(link_clk),
      .fetch_req_i(req), .fetch_addr_i(addr), .dual_mode_en_i(dual_en),
      .flash_io0_i(io0_w), .flash_serial_in_i(f_io1), .fetch_rdy_o(rdy),
      .fetch_data_o(data), .ext_code_en_o(ext), .cpu_hold_o(hold),
      .rate_fast_o(fast), .flash_sel_b_o(sel_b), .flash_sclk_o(sclk),
      .flash_io0_o(d_io0), .flash_io0_oe_o(d_oe));
   flash_model u_flash (
      .sel_b_i(sel_b), .sclk_i(sclk), .io0_i(io0_w), .sig_ok_i(sig_ok),
      .io0_o(f_io0), .io0_oe_o(f_oe), .io1_o(f_io1));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.3;
      forever #7.5 link_clk = ~link_clk;
   end

   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         fails++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic do_reset(input logic st, input logic ok);
      int n;
      rst_b <= 1'b0;
      strap <= st;
      sig_ok <= ok;
      st_l = st;
      open_s = 1'b0;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hold !== 1'b0 && n < 2000);
      chk(n < 2000, "probe never ended");
   endtask

   task automatic fetch(input logic [23:0] a, input logic de, input logic ex);
      int n;
      if (!(open_s && a == last_a + 24'h1)) begin
         mode = de && !st_l;
         nb = 0;
         opens0 = u_flash.opens;
      end
      req <= 1'b1;
      addr <= a;
      dual_en <= de;
      @(posedge core_clk);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (rdy !== 1'b1 && n < 600);
      if (!ex) begin
         chk(n == 600, "fetch served without signature");
         return;
      end
      nb++;
      open_s = 1'b1;
      last_a = a;
      chk(n < 600 && data === u_flash.mem_byte(a), "fetched byte");
      chk(u_flash.opens == opens0 + 1, "select not restarted");
      chk(u_flash.hdr === {mode ? 8'h3B : 8'h0B, a - 24'(nb-1)}, "hdr");
      chk(u_flash.cnt == 40 + nb * (mode ? 4 : 8), "clock count");
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin
      rs = 32'h0470;
      fails = 0;
      compares = 0;
      req = 1'b0;
      addr = 24'h0;
      dual_en = 1'b0;
      do_reset(1'b0, 1'b0);
      chk(ext === 1'b0, "external code chosen");
      fetch(24'h000010, 1'b0, 1'b0);
      $display("test no_signature done");
      do_reset(1'b0, 1'b1);
      chk(ext === 1'b1 && fast === 1'b0, "boot selection");
      fetch(24'h000000, 1'b0, 1'b1);
      strap <= 1'b1;
      for (int i = 0; i < 24; i++) begin
         r = xs();
         fetch(r[1:0] != 2'h0 ? last_a + 24'h1 : r[31:8], r[4], 1'b1);
      end
      // dual open and one streamed dual byte, whatever the seed gave
      fetch(24'h00FFFA, 1'b1, 1'b1);
      fetch(24'h00FFFB, 1'b1, 1'b1);
      chk(fast === 1'b0, "strap not held");
      $display("test stream done");
      do_reset(1'b1, 1'b1);
      chk(fast === 1'b1, "fast strap");
      r = xs();
      fetch(r[23:0], 1'b1, 1'b1);
      fetch(last_a + 24'h1, 1'b1, 1'b1);
      $display("test fast_rate done");
      report_and_stop();
   end
endmodule
